/* ceo_core.sv */
// ==========================================================
// Extended-operation core with register sets and special registers
module ceo_core (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   arst_n,
  // Operation request
  input  wire logic                   op_start,
  input  wire ceo_pkg::ceo_op_t       op_code,
  input  wire logic [2:0]             op_sel,
  input  wire logic [15:0]            op_imm,
  output logic                        op_ready,
  // Fetch, wake and indexed address
  input  wire logic                   opcode_fetch_cycle,
  input  wire logic                   wake,
  input  wire logic                   index_sel,
  input  wire logic [7:0]             disp_byte,
  output logic      [15:0]            indexed_addr,
  // Memory and port bus
  output logic      [15:0]            bus_addr,
  output logic      [7:0]             bus_wdata,
  output logic                        bus_mem_rd,
  output logic                        bus_io_rd,
  output logic                        bus_io_wr,
  input  wire logic [7:0]             bus_rdata,
  // Visible state
  output logic      [7:0]             acc,
  output logic      [7:0]             flags,
  output logic      [15:0]            count_port_pair,
  output logic      [15:0]            second_general_pair,
  output logic      [15:0]            memory_pointer_pair,
  output logic      [15:0]            stack_pointer,
  output logic      [15:0]            program_counter,
  output logic      [15:0]            index_one,
  output logic      [15:0]            index_two,
  output logic      [7:0]             vector_page,
  output logic      [7:0]             fetch_tally,
  output logic                        sleep_mode
);

  typedef enum logic [1:0] { st_idle, st_read, st_again } ceo_state_t;

  // ==========================================================
  // State
  ceo_state_t       state_reg, state_next;
  ceo_pkg::ceo_op_t op_reg, op_next;
  logic [2:0]       sel_reg, sel_next;
  logic [7:0]       imm_reg, imm_next;
  logic [7:0]       main_set_reg [8];
  logic [7:0]       main_set_next [8];
  logic [7:0]       alternate_set_reg [8];
  logic [7:0]       alternate_set_next [8];
  logic [15:0]      sp_reg, sp_next, pc_reg, pc_next;
  logic [15:0]      ix_reg, ix_next, iy_reg, iy_next;
  logic [7:0]       vec_reg, vec_next, tally_reg, tally_next;
  logic             sleep_reg, sleep_next;
  logic [15:0]      addr_reg, addr_next, ea_reg, ea_next;
  logic [7:0]       wdata_reg, wdata_next;
  logic             mem_rd_reg, mem_rd_next, io_rd_reg, io_rd_next;
  logic             io_wr_reg, io_wr_next;

  logic [7:0]       mul_hi, mul_lo, and_x, and_y, new_flags;
  logic [15:0]      mul_p, hl_word, hl_step;
  logic             blk_up, blk_rep;

  ceo_mul8 u_mul (
    .mul_a (mul_hi),
    .mul_b (mul_lo),
    .mul_p (mul_p)
  );

  ceo_and_flags u_flags (
    .and_x     (and_x),
    .and_y     (and_y),
    .flags_in  (main_set_reg[ceo_pkg::SEL_FLAGS]),
    .flags_out (new_flags)
  );

  // Multiplier operands: high and low byte of the selected pair
  always_comb
  begin
    if (op_sel[1:0] == ceo_pkg::PAIR_SP)
    begin
      mul_hi = sp_reg[15:8];
      mul_lo = sp_reg[7:0];
    end
    else
    begin
      mul_hi = main_set_reg[{op_sel[1:0], 1'b0}];
      mul_lo = main_set_reg[{op_sel[1:0], 1'b1}];
    end
  end

  // AND operands; port test pairs the port byte with the immediate
  always_comb
  begin
    and_x = main_set_reg[ceo_pkg::SEL_ACC];
    and_y = bus_rdata;
    if (state_reg == st_idle)
    begin
      and_y = (op_code == ceo_pkg::op_and_test_reg) ? main_set_reg[op_sel] : op_imm[7:0];
    end
    else if (op_reg == ceo_pkg::op_port_test)
    begin
      and_x = imm_reg;
    end
  end

  // Block step helpers
  assign blk_up  = (op_reg == ceo_pkg::op_block_out_up) ||
                   (op_reg == ceo_pkg::op_block_out_up_repeat);
  assign blk_rep = (op_reg == ceo_pkg::op_block_out_up_repeat) ||
                   (op_reg == ceo_pkg::op_block_out_down_repeat);
  assign hl_word = {main_set_reg[ceo_pkg::SEL_H], main_set_reg[ceo_pkg::SEL_L]};
  assign hl_step = blk_up ? hl_word + 16'h0001 : hl_word - 16'h0001;

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    state_next         = state_reg;
    op_next            = op_reg;
    sel_next           = sel_reg;
    imm_next           = imm_reg;
    main_set_next      = main_set_reg;
    alternate_set_next = alternate_set_reg;
    sp_next            = sp_reg;
    pc_next            = pc_reg;
    ix_next            = ix_reg;
    iy_next            = iy_reg;
    vec_next           = vec_reg;
    tally_next         = tally_reg;
    sleep_next         = sleep_reg;
    addr_next          = addr_reg;
    wdata_next         = wdata_reg;
    mem_rd_next        = 1'b0;
    io_rd_next         = 1'b0;
    io_wr_next         = 1'b0;
    // Signed displacement covers both add and subtract
    ea_next = (index_sel ? iy_reg : ix_reg) + {{8{disp_byte[7]}}, disp_byte};
    if (opcode_fetch_cycle)
    begin
      pc_next    = pc_reg + 16'h0001;
      tally_next = {tally_reg[7], tally_reg[6:0] + 7'h01};
    end
    if (wake)
    begin
      sleep_next = 1'b0;
    end
    case (state_reg)
      st_idle:
      begin
        if (op_start && !sleep_reg)
        begin
          op_next  = op_code;
          sel_next = op_sel;
          imm_next = op_imm[7:0];
          case (op_code)
            ceo_pkg::op_multiply:
            begin
              // Flags untouched on purpose
              if (op_sel[1:0] == ceo_pkg::PAIR_SP)
              begin
                sp_next = mul_p;
              end
              else
              begin
                main_set_next[{op_sel[1:0], 1'b0}] = mul_p[15:8];
                main_set_next[{op_sel[1:0], 1'b1}] = mul_p[7:0];
              end
            end
            ceo_pkg::op_and_test_reg, ceo_pkg::op_and_test_imm:
            begin
              main_set_next[ceo_pkg::SEL_FLAGS] = new_flags;
            end
            ceo_pkg::op_and_test_mem, ceo_pkg::op_block_out_up,
            ceo_pkg::op_block_out_up_repeat, ceo_pkg::op_block_out_down,
            ceo_pkg::op_block_out_down_repeat:
            begin
              addr_next   = hl_word;
              mem_rd_next = 1'b1;
              state_next  = st_read;
            end
            ceo_pkg::op_port_test:
            begin
              addr_next  = {ceo_pkg::PORT_PAGE, main_set_reg[ceo_pkg::SEL_C]};
              io_rd_next = 1'b1;
              state_next = st_read;
            end
            ceo_pkg::op_imm_port_in:
            begin
              addr_next  = {ceo_pkg::PORT_PAGE, op_imm[7:0]};
              io_rd_next = 1'b1;
              state_next = st_read;
            end
            ceo_pkg::op_imm_port_out:
            begin
              addr_next  = {ceo_pkg::PORT_PAGE, op_imm[7:0]};
              wdata_next = main_set_reg[op_sel];
              io_wr_next = 1'b1;
            end
            ceo_pkg::op_sleep:
            begin
              sleep_next = 1'b1;
            end
            ceo_pkg::op_swap_af:
            begin
              // One of two paths into the alternate set; op_swap_pairs is the other
              main_set_next[ceo_pkg::SEL_FLAGS]      = alternate_set_reg[ceo_pkg::SEL_FLAGS];
              main_set_next[ceo_pkg::SEL_ACC]        = alternate_set_reg[ceo_pkg::SEL_ACC];
              alternate_set_next[ceo_pkg::SEL_FLAGS] = main_set_reg[ceo_pkg::SEL_FLAGS];
              alternate_set_next[ceo_pkg::SEL_ACC]   = main_set_reg[ceo_pkg::SEL_ACC];
            end
            ceo_pkg::op_swap_pairs:
            begin
              for (int i = 0; i < 6; i++)
              begin
                main_set_next[i]      = alternate_set_reg[i];
                alternate_set_next[i] = main_set_reg[i];
              end
            end
            ceo_pkg::op_load_byte:
            begin
              main_set_next[op_sel] = op_imm[7:0];
            end
            ceo_pkg::op_load_word:
            begin
              case (op_sel)
                ceo_pkg::WSEL_SP:  sp_next  = op_imm;
                ceo_pkg::WSEL_IX:  ix_next  = op_imm;
                ceo_pkg::WSEL_IY:  iy_next  = op_imm;
                ceo_pkg::WSEL_VEC: vec_next = op_imm[7:0];
                3'h7:              pc_next  = op_imm;
                default:
                begin
                  main_set_next[{op_sel[1:0], 1'b0}] = op_imm[15:8];
                  main_set_next[{op_sel[1:0], 1'b1}] = op_imm[7:0];
                end
              endcase
            end
            default:
            begin
              state_next = st_idle;
            end
          endcase
        end
      end
      st_read:
      begin
        state_next = st_idle;
        case (op_reg)
          ceo_pkg::op_and_test_mem, ceo_pkg::op_port_test:
          begin
            main_set_next[ceo_pkg::SEL_FLAGS] = new_flags;
          end
          ceo_pkg::op_imm_port_in:
          begin
            main_set_next[sel_reg] = bus_rdata;
          end
          default:
          begin
            // Block step: write the fetched byte, then move pointers
            addr_next  = {ceo_pkg::PORT_PAGE, main_set_reg[ceo_pkg::SEL_C]};
            wdata_next = bus_rdata;
            io_wr_next = 1'b1;
            main_set_next[ceo_pkg::SEL_H] = hl_step[15:8];
            main_set_next[ceo_pkg::SEL_L] = hl_step[7:0];
            main_set_next[ceo_pkg::SEL_C] = blk_up ? main_set_reg[ceo_pkg::SEL_C] + 8'h01
                                                   : main_set_reg[ceo_pkg::SEL_C] - 8'h01;
            main_set_next[ceo_pkg::SEL_B] = main_set_reg[ceo_pkg::SEL_B] - 8'h01;
            if (blk_rep && (main_set_reg[ceo_pkg::SEL_B] != 8'h01))
            begin
              state_next = st_again;
            end
          end
        endcase
      end
      st_again:
      begin
        // Gap cycle lets the port write finish before the next read
        addr_next   = hl_word;
        mem_rd_next = 1'b1;
        state_next  = st_read;
      end
      default:
      begin
        state_next = st_idle;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= st_idle;
      op_reg    <= ceo_pkg::op_multiply;
      sel_reg   <= 3'h0;
      imm_reg   <= ceo_pkg::RST_BYTE;
      for (int i = 0; i < 8; i++)
      begin
        main_set_reg[i]      <= ceo_pkg::RST_BYTE;
        alternate_set_reg[i] <= ceo_pkg::RST_BYTE;
      end
      sp_reg     <= ceo_pkg::RST_WORD;
      pc_reg     <= ceo_pkg::RST_WORD;
      ix_reg     <= ceo_pkg::RST_WORD;
      iy_reg     <= ceo_pkg::RST_WORD;
      vec_reg    <= ceo_pkg::RST_BYTE;
      tally_reg  <= ceo_pkg::RST_BYTE;
      sleep_reg  <= 1'b0;
      addr_reg   <= ceo_pkg::RST_WORD;
      ea_reg     <= ceo_pkg::RST_WORD;
      wdata_reg  <= ceo_pkg::RST_BYTE;
      mem_rd_reg <= 1'b0;
      io_rd_reg  <= 1'b0;
      io_wr_reg  <= 1'b0;
    end
    else
    begin
      state_reg         <= state_next;
      op_reg            <= op_next;
      sel_reg           <= sel_next;
      imm_reg           <= imm_next;
      main_set_reg      <= main_set_next;
      alternate_set_reg <= alternate_set_next;
      sp_reg            <= sp_next;
      pc_reg            <= pc_next;
      ix_reg            <= ix_next;
      iy_reg            <= iy_next;
      vec_reg           <= vec_next;
      tally_reg         <= tally_next;
      sleep_reg         <= sleep_next;
      addr_reg          <= addr_next;
      ea_reg            <= ea_next;
      wdata_reg         <= wdata_next;
      mem_rd_reg        <= mem_rd_next;
      io_rd_reg         <= io_rd_next;
      io_wr_reg         <= io_wr_next;
    end
  end

  // ==========================================================
  // Outputs
  assign op_ready            = (state_reg == st_idle) && !sleep_reg;
  assign indexed_addr        = ea_reg;
  assign bus_addr            = addr_reg;
  assign bus_wdata           = wdata_reg;
  assign bus_mem_rd          = mem_rd_reg;
  assign bus_io_rd           = io_rd_reg;
  assign bus_io_wr           = io_wr_reg;
  assign acc                 = main_set_reg[ceo_pkg::SEL_ACC];
  assign flags               = main_set_reg[ceo_pkg::SEL_FLAGS];
  assign count_port_pair     = {main_set_reg[0], main_set_reg[1]};
  assign second_general_pair = {main_set_reg[2], main_set_reg[3]};
  assign memory_pointer_pair = hl_word;
  assign stack_pointer       = sp_reg;
  assign program_counter     = pc_reg;
  assign index_one           = ix_reg;
  assign index_two           = iy_reg;
  assign vector_page         = vec_reg;
  assign fetch_tally         = tally_reg;
  assign sleep_mode          = sleep_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  logic take;
  assign take = op_start && op_ready;

  mult_product_a: assert property (take && op_code == ceo_pkg::op_multiply && op_sel == 3'h0
    |=> count_port_pair == 16'($past(main_set_reg[0])) * 16'($past(main_set_reg[1])))
    else $error("multiply product wrong");

  mult_flags_a: assert property (take && op_code == ceo_pkg::op_multiply && !opcode_fetch_cycle
    |=> $stable(flags))
    else $error("multiply changed flags");

  port_page_a: assert property (bus_io_rd || bus_io_wr |-> bus_addr[15:8] == 8'h00)
    else $error("port upper address not zero");

  block_step_a: assert property (state_reg == st_read
    && (op_reg == ceo_pkg::op_block_out_up || op_reg == ceo_pkg::op_block_out_up_repeat)
    |=> memory_pointer_pair == $past(hl_word) + 16'h0001 && bus_io_wr
        && count_port_pair[15:8] == $past(main_set_reg[0]) - 8'h01)
    else $error("block step pointers wrong");

  block_repeat_a: assert property (bus_io_wr && blk_rep && count_port_pair[15:8] != 8'h00
    |=> bus_mem_rd && state_reg == st_read)
    else $error("repeat block did not continue");

  test_keeps_a: assert property (take && op_code == ceo_pkg::op_and_test_reg
    |=> $stable(acc) && $stable(count_port_pair) && $stable(memory_pointer_pair))
    else $error("register test modified data");

  test_zero_a: assert property (take && op_code == ceo_pkg::op_and_test_imm
    |=> flags[6] == (($past(acc) & $past(op_imm[7:0])) == 8'h00) && flags[7] == $past(acc[7] & op_imm[7]))
    else $error("zero or sign flag wrong");

  test_parity_a: assert property (take && op_code == ceo_pkg::op_and_test_imm
    |=> flags[2] == ~(^($past(acc) & $past(op_imm[7:0]))) && flags[4] && !flags[1] && !flags[0])
    else $error("parity or fixed flags wrong");

  sleep_entry_a: assert property (take && op_code == ceo_pkg::op_sleep |=> sleep_mode && !op_ready)
    else $error("sleep not entered");

  fetch_count_a: assert property (opcode_fetch_cycle && state_reg == st_idle && !op_start
    |=> program_counter == $past(program_counter) + 16'h0001
        && fetch_tally[6:0] == $past(fetch_tally[6:0]) + 7'h01)
    else $error("fetch did not advance counters");

endmodule

/* ceo_pkg.sv */
// Summary of operation
// - Multiply treats both bytes as unsigned, full 16-bit product kept.
// - Multiply picks a pair or stack pointer; high times low, product back there.
// - Block out: memory at pointer pair to port index; both step up or down.
// - Each block step decrements count; repeat forms run until count hits zero.
// - Port accesses of these operations drive zero on the upper address byte.
// - Port test ANDs port byte with immediate, sets flags, writes no port.
// - Register test ANDs register with accumulator; neither one is changed.
// - Immediate test ANDs immediate with accumulator; accumulator unchanged.
// - Memory test ANDs pointer-pair byte with accumulator; nothing written.
// - Immediate input loads port at instruction address into chosen register.
// - Immediate output writes chosen register to port at instruction address.
// - Sleep operation puts the processor into low power sleep state.
// - Alternate accumulator, flags and pairs only reachable by swapping.
// - General pairs usable as one word or as two separate bytes.
// - Vector page gives top vector address byte; reset clears it.
// - Fetch tally counts every opcode fetch in low seven bits; reset clears.
// - Reset clears the stack pointer.
// - Reset clears program counter; it advances after every fetch, unless a word load sets it in that cycle.
// - Indexed address is index register plus signed instruction displacement.
// - Index registers, stack pointer, program counter 16 bits; page, tally 8.
// - Zero flag set on zero result; sign flag copies result top bit.
// - Parity flag set for even count of one bits in logical results.
package ceo_pkg;

  // ==========================================================
  // Register file indices (byte select field)
  localparam logic [2:0] SEL_B     = 3'h0;
  localparam logic [2:0] SEL_C     = 3'h1;
  localparam logic [2:0] SEL_H     = 3'h4;
  localparam logic [2:0] SEL_L     = 3'h5;
  localparam logic [2:0] SEL_FLAGS = 3'h6;
  localparam logic [2:0] SEL_ACC   = 3'h7;

  // ==========================================================
  // Word load targets and multiply pair codes
  localparam logic [2:0] WSEL_SP   = 3'h3;
  localparam logic [2:0] WSEL_IX   = 3'h4;
  localparam logic [2:0] WSEL_IY   = 3'h5;
  localparam logic [2:0] WSEL_VEC  = 3'h6;
  localparam logic [1:0] PAIR_SP   = 2'h3;

  // ==========================================================
  // Flag bit positions
  localparam int FLAG_S  = 7;
  localparam int FLAG_Z  = 6;
  localparam int FLAG_H  = 4;
  localparam int FLAG_PV = 2;
  localparam int FLAG_N  = 1;
  localparam int FLAG_C  = 0;

  // ==========================================================
  // Reset values and port page
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [7:0]  PORT_PAGE = 8'h00;

  // ==========================================================
  // Operation codes
  typedef enum logic [3:0] {
    op_multiply,
    op_and_test_reg,
    op_and_test_imm,
    op_and_test_mem,
    op_port_test,
    op_imm_port_in,
    op_imm_port_out,
    op_block_out_up,
    op_block_out_up_repeat,
    op_block_out_down,
    op_block_out_down_repeat,
    op_sleep,
    op_swap_af,
    op_swap_pairs,
    op_load_byte,
    op_load_word
  } ceo_op_t;

endpackage

/* ceo_mul8.sv */
// ==========================================================
// Unsigned byte multiplier
module ceo_mul8 (
  // Operands
  input  wire logic [7:0]  mul_a,
  input  wire logic [7:0]  mul_b,
  // Product
  output logic      [15:0] mul_p
);

  // Zero extension keeps both operands unsigned
  assign mul_p = {8'h00, mul_a} * {8'h00, mul_b};

endmodule

/* ceo_and_flags.sv */
// ==========================================================
// Flag byte for a non-destructive AND
module ceo_and_flags (
  // Operands and previous flags
  input  wire logic [7:0] and_x,
  input  wire logic [7:0] and_y,
  input  wire logic [7:0] flags_in,
  // Result flags
  output logic      [7:0] flags_out
);

  logic [7:0] res;

  // Unused bits 5 and 3 keep their old value
  always_comb
  begin
    res                           = and_x & and_y;
    flags_out                     = flags_in;
    flags_out[ceo_pkg::FLAG_S]    = res[7];
    flags_out[ceo_pkg::FLAG_Z]    = (res == 8'h00);
    flags_out[ceo_pkg::FLAG_PV]   = ~(^res);
    flags_out[ceo_pkg::FLAG_H]    = 1'b1;
    flags_out[ceo_pkg::FLAG_N]    = 1'b0;
    flags_out[ceo_pkg::FLAG_C]    = 1'b0;
  end

endmodule

/* ceo_bus_model.sv */
// ==========
// Memory and port model
module ceo_bus_model (
  // Clock
  input  wire logic        core_clk,
  // Core bus
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_mem_rd,
  input  wire logic        bus_io_rd,
  input  wire logic        bus_io_wr,
  // Read data and write log
  output logic      [7:0]  bus_rdata,
  output logic      [15:0] wr_addr,
  output logic      [7:0]  wr_data,
  output int               wr_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_q = 8'h00;
  int         wr_cnt = 0;
  // Single driver for the write tally
  assign wr_count = wr_cnt;
  // Data only under a strobe; inverse otherwise so stale data never matches
  always_comb
  begin
    if (bus_mem_rd)
      bus_rdata = bus_addr[7:0] ^ 8'hA5;
    else if (bus_io_rd)
      bus_rdata = bus_addr[7:0] + 8'h33;
    else
      bus_rdata = ~last_q;
  end
  // Log every port write
  always @(posedge core_clk)
  begin
    if (bus_mem_rd || bus_io_rd)
      last_q <= bus_rdata;
    if (bus_io_wr)
    begin
      wr_addr  <= bus_addr;
      wr_data  <= bus_wdata;
      wr_cnt   <= wr_cnt + 1;
    end
  end
endmodule

/* testbench.sv */
// ==========
// Core bench
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 0, arst_n = 0, op_start = 0, opcode_fetch_cycle = 0, wake = 0;
  logic        index_sel = 0, op_ready, bus_mem_rd, bus_io_rd, bus_io_wr, sleep_mode;
  logic [2:0]  op_sel = 3'h0;
  logic [7:0]  disp_byte = 8'h00, bus_wdata, bus_rdata, acc, flags, vector_page;
  logic [7:0]  fetch_tally, wr_data;
  logic [15:0] op_imm = 16'h0000, indexed_addr, bus_addr, count_port_pair, index_one;
  logic [15:0] second_general_pair, memory_pointer_pair, stack_pointer, program_counter;
  logic [15:0] index_two, wr_addr;
  int          num_errors = 0, num_checks = 0, wr_count, wn;
  ceo_pkg::ceo_op_t op_code = ceo_pkg::op_load_byte;
  ceo_core DUT (.core_clk, .arst_n, .op_start, .op_code, .op_sel, .op_imm, .op_ready,
    .opcode_fetch_cycle, .wake, .index_sel, .disp_byte, .indexed_addr, .bus_addr,
    .bus_wdata, .bus_mem_rd, .bus_io_rd, .bus_io_wr, .bus_rdata, .acc, .flags,
    .count_port_pair, .second_general_pair, .memory_pointer_pair, .stack_pointer,
    .program_counter, .index_one, .index_two, .vector_page, .fetch_tally, .sleep_mode);
  ceo_bus_model partner (.core_clk, .bus_addr, .bus_wdata, .bus_mem_rd, .bus_io_rd,
    .bus_io_wr, .bus_rdata, .wr_addr, .wr_data, .wr_count);
  // 10 MHz clock
  initial forever #50 core_clk = ~core_clk;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize;
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask
  // One operation; extra cycle lets the partner log a final write
  task op(input ceo_pkg::ceo_op_t c, input logic [2:0] s, input logic [15:0] i);
    int n;
    n = 0;
    op_start = 1;
    op_code = c;
    op_sel = s;
    op_imm = i;
    step(1);
    op_start = 0;
    while (op_ready !== 1'b1 && n < 600)
    begin
      step(1);
      n++;
    end
    if (op_ready !== 1'b1)
    begin
      num_errors++;
      summarize();
    end
    step(1);
  endtask
  task t_reset_fetch;
    chk(stack_pointer, 16'h0000);
    chk({vector_page, fetch_tally}, 16'h0000);
    opcode_fetch_cycle = 1;
    step(3);
    opcode_fetch_cycle = 0;
    chk(program_counter, 16'h0003);
    chk(16'(fetch_tally), 16'h0003);
  endtask
  task t_mul;
    op(ceo_pkg::op_load_word, 3'h0, 16'hFFFE);
    op(ceo_pkg::op_load_word, 3'h3, 16'h0D0C);
    op(ceo_pkg::op_multiply, 3'h0, 16'h0000);
    op(ceo_pkg::op_multiply, 3'h3, 16'h0000);
    chk(count_port_pair, 16'hFD02);
    chk(stack_pointer, 16'h009C);
    chk(16'(flags), 16'h0000);
  endtask
  task t_tests;
    op(ceo_pkg::op_load_byte, 3'h7, 16'h0096);
    op(ceo_pkg::op_and_test_imm, 3'h0, 16'h0081);
    chk({acc, flags}, 16'h9690);
    op(ceo_pkg::op_and_test_imm, 3'h0, 16'h0069);
    chk(16'(flags), 16'h0054);
    op(ceo_pkg::op_load_byte, 3'h3, 16'h000F);
    op(ceo_pkg::op_and_test_reg, 3'h3, 16'h0000);
    chk({acc, flags}, 16'h9614);
    chk(second_general_pair, 16'h000F);
    op(ceo_pkg::op_swap_af, 3'h0, 16'h0000);
    chk({acc, flags}, 16'h0000);
    op(ceo_pkg::op_swap_af, 3'h0, 16'h0000);
    op(ceo_pkg::op_multiply, 3'h1, 16'h0000);
    chk(16'(flags), 16'h0014);
    op(ceo_pkg::op_swap_pairs, 3'h0, 16'h0000);
    chk(count_port_pair | second_general_pair, 16'h0000);
    op(ceo_pkg::op_swap_pairs, 3'h0, 16'h0000);
    chk(count_port_pair, 16'hFD02);
  endtask
  // Repeat and single-step block output, then a memory test
  task t_block;
    op(ceo_pkg::op_load_word, 3'h0, 16'h0210);
    op(ceo_pkg::op_load_word, 3'h2, 16'h2000);
    wn = wr_count;
    op(ceo_pkg::op_block_out_up_repeat, 3'h0, 16'h0000);
    chk(16'(wr_count - wn), 16'h0002);
    chk(wr_addr, 16'h0011);
    chk({memory_pointer_pair[7:0], wr_data}, 16'h02A4);
    chk(count_port_pair, 16'h0012);
    op(ceo_pkg::op_load_word, 3'h0, 16'h0512);
    op(ceo_pkg::op_block_out_down, 3'h0, 16'h0000);
    chk({wr_addr[7:0], wr_data}, 16'h12A7);
    chk(memory_pointer_pair, 16'h2001);
    chk(count_port_pair, 16'h0411);
    op(ceo_pkg::op_and_test_mem, 3'h0, 16'h0000);
    chk({acc, flags}, 16'h9694);
  endtask
  task t_ports;
    wn = wr_count;
    op(ceo_pkg::op_port_test, 3'h0, 16'h000B);
    chk(16'(flags), 16'h0054);
    chk(16'(wr_count - wn), 16'h0000);
    op(ceo_pkg::op_imm_port_in, 3'h0, 16'h0040);
    chk(count_port_pair, 16'h7311);
    op(ceo_pkg::op_imm_port_out, 3'h7, 16'h0080);
    chk(wr_addr, 16'h0080);
    chk(16'(wr_data), 16'h0096);
  endtask
  task t_index_sleep;
    op(ceo_pkg::op_load_word, 3'h4, 16'h1000);
    op(ceo_pkg::op_load_word, 3'h5, 16'h3000);
    op(ceo_pkg::op_load_word, 3'h6, 16'h00A5);
    op(ceo_pkg::op_load_word, 3'h7, 16'h4000);
    chk(program_counter, 16'h4000);
    chk({index_one[15:8], vector_page}, 16'h10A5);
    disp_byte = 8'hFE;
    step(2);
    chk(indexed_addr, 16'h0FFE);
    index_sel = 1;
    disp_byte = 8'h05;
    step(2);
    chk(indexed_addr, 16'h3005);
    chk(index_two, 16'h3000);
    op_start = 1;
    op_code = ceo_pkg::op_sleep;
    step(1);
    // Request left standing while asleep must be ignored
    op_code = ceo_pkg::op_load_byte;
    op_sel = 3'h0;
    op_imm = 16'h00EE;
    chk(16'({sleep_mode, op_ready}), 16'h0002);
    step(1);
    op_start = 0;
    wake = 1;
    chk(count_port_pair, 16'h7311);
    step(1);
    wake = 0;
    chk(16'(sleep_mode), 16'h0000);
  endtask
  // Mid-run reset after the special registers hold non-zero values
  task t_reset_again;
    arst_n = 0;
    step(2);
    arst_n = 1;
    chk(stack_pointer, 16'h0000);
    chk(program_counter, 16'h0000);
    chk({vector_page, fetch_tally}, 16'h0000);
  endtask
  initial
  begin
    step(6);
    arst_n = 1;
    t_reset_fetch();
    t_mul();
    t_tests();
    t_block();
    t_ports();
    t_index_sleep();
    t_reset_again();
    summarize();
  end
endmodule
